// [lpc_led_load.sv]
// Far-side model: LEDs and external logic sources on the ten port pins
`default_nettype none
module lpc_led_load
    import lpc_pkg::*;
(
    // Drive from the block
    input  wire lpc_drive_t port_drive,
    // Level each external source or pull-up presents when the pin is free
    input  wire logic [9:0] ext_level,
    // Pin levels seen back by the block
    output var  logic [9:0] port_io_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Open-drain pin: a pull low wins over any source; a sinking LED leaves it pulled up
    always_comb begin
        port_io_in = ext_level & ~port_drive.oe;
    end
endmodule // lpc_led_load
`default_nettype wire

// [lpc_pkg.sv]
// Package: register map, reset values, timing constants and carrier types of the port PWM block
`default_nettype none
package lpc_pkg;
    localparam int         LPC_NUM_PORTS      = 10;
    localparam logic [7:0] LPC_ADDR_PORT0     = 8'h00;
    localparam logic [7:0] LPC_ADDR_PORT9     = 8'h09;
    localparam logic [7:0] LPC_ADDR_INSTAT_LO = 8'h0E;
    localparam logic [7:0] LPC_ADDR_INSTAT_HI = 8'h0F;
    localparam logic [7:0] LPC_ADDR_CONFIG    = 8'h10;
    localparam logic [7:0] LPC_ADDR_SCALE_LO  = 8'h13;
    localparam logic [7:0] LPC_ADDR_SCALE_HI  = 8'h14;
    localparam logic [7:0] LPC_ADDR_GLOBAL    = 8'h15;
    localparam logic [7:0] LPC_CODE_LOW       = 8'h00;
    localparam logic [7:0] LPC_CODE_INPUT     = 8'h01;
    localparam logic [7:0] LPC_CODE_STATIC    = 8'h02;
    localparam logic [7:0] LPC_CODE_PWM_MIN   = 8'h03;
    localparam logic [7:0] LPC_CODE_PWM_MAX   = 8'hFE;
    localparam int         LPC_CFG_RUN_BIT    = 0;
    localparam int         LPC_CFG_STAG_BIT   = 5;
    localparam int         LPC_CFG_CLKSEL_BIT = 7;
    // Writable configuration bits; 4:2 are status bits of the ramp logic and read 0 here
    localparam logic [7:0] LPC_CFG_RW_MASK    = 8'hE3;
    localparam logic [7:0] LPC_RST_PORT       = 8'hFF;
    localparam logic [7:0] LPC_RST_CONFIG     = 8'h00;
    localparam logic [7:0] LPC_RST_CONFIG_EXT = 8'h80;
    localparam logic [7:0] LPC_RST_SCALE      = 8'h00;
    localparam logic [7:0] LPC_RST_GLOBAL     = 8'h07;
    localparam logic [2:0] LPC_GLOBAL_MASK    = 3'h7;
    localparam logic [7:0] LPC_STAGGER_STEP   = 8'h20;
    localparam logic [7:0] LPC_PWM_LAST       = 8'hFF;
    localparam int         LPC_CLK_PERIOD_NS  = 5;
    localparam int         LPC_OSC_HZ         = 32000;
    localparam int         LPC_OSC_PERIOD_NS  = 1000000000 / LPC_OSC_HZ;
    localparam int         LPC_OSC_DIV_CYCLES = LPC_OSC_PERIOD_NS / LPC_CLK_PERIOD_NS;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lpc_reg_req_t;

    typedef struct packed {
        logic [9:0] out;
        logic [9:0] oe;
        logic [9:0] sink;
        logic [9:0] full;
    } lpc_drive_t;
endpackage
`default_nettype wire

// [lpc_port_pwm.sv]
// Ten-port LED driver: port codes, current scaling, PWM timebase and input readback
`default_nettype none
module lpc_port_pwm
    import lpc_pkg::*;
#(
    parameter bit HAS_EXT_CLK = 1'b1,
    parameter int OSC_DIV     = LPC_OSC_DIV_CYCLES
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         arst_n,
    // Register port, behind the serial interface
    input  wire lpc_reg_req_t reg_req,
    output var  logic [7:0]   reg_rdata,
    // External PWM clock pin
    input  wire logic         ext_pwm_clock_in,
    // Port pins and current mirror controls
    input  wire logic [9:0]   port_io_in,
    output var  lpc_drive_t   port_drive,
    output var  logic [2:0]   global_current
);
    localparam int N = LPC_NUM_PORTS;

    // Divider must fit the 13-bit tick counter
    if (OSC_DIV < 2 || OSC_DIV > 8191) begin : g_bad_osc_div
        $error("OSC_DIV out of range");
    end

    function automatic logic [7:0] phase_of(input int n, input logic stagger);
        return stagger ? 8'((n * int'(LPC_STAGGER_STEP)) % 256) : 8'h00;
    endfunction

    // Address decode shared by the write and read paths
    function automatic logic is_port_addr(input logic [7:0] addr);
        return addr <= LPC_ADDR_PORT9;
    endfunction

    // Codes whose sink follows the PWM counter
    function automatic logic is_pwm_code(input logic [7:0] code);
        return code >= LPC_CODE_PWM_MIN && code <= LPC_CODE_PWM_MAX;
    endfunction

    // Register file
    logic [7:0] port_cfg_reg [N];
    logic [7:0] port_cfg_next [N];
    logic [7:0] config_reg, config_next;
    logic [7:0] scale_lo_reg, scale_lo_next;
    logic [7:0] scale_hi_reg, scale_hi_next;
    logic [7:0] global_reg, global_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [9:0] input_mask;
    logic [7:0] cfg_wdata;

    // Timebase and pin synchronisers
    logic [10:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;
    logic [12:0] osc_cnt_reg, osc_cnt_next;
    logic [7:0]  pwm_cnt_reg, pwm_cnt_next;
    logic        osc_tick, ext_tick, pwm_tick;

    // Drive
    lpc_drive_t drive_reg, drive_next;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            input_mask[i] = (port_cfg_reg[i] == LPC_CODE_INPUT);
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            port_cfg_next[i] = port_cfg_reg[i];
        end
        config_next   = config_reg;
        scale_lo_next = scale_lo_reg;
        scale_hi_next = scale_hi_reg;
        global_next   = global_reg;
        rdata_next    = rdata_reg;
        cfg_wdata     = reg_req.wdata & LPC_CFG_RW_MASK;
        if (!HAS_EXT_CLK) begin
            cfg_wdata[LPC_CFG_CLKSEL_BIT] = 1'b0;
        end
        if (reg_req.wr) begin
            if (is_port_addr(reg_req.addr)) begin
                port_cfg_next[reg_req.addr[3:0]] = reg_req.wdata;
            end else if (reg_req.addr == LPC_ADDR_CONFIG) begin
                config_next = cfg_wdata;
            end else if (reg_req.addr == LPC_ADDR_SCALE_LO) begin
                scale_lo_next = reg_req.wdata;
            end else if (reg_req.addr == LPC_ADDR_SCALE_HI) begin
                scale_hi_next = reg_req.wdata;
            end else if (reg_req.addr == LPC_ADDR_GLOBAL) begin
                global_next = reg_req.wdata;
            end
            // Status addresses and unmapped ones fall through untouched
        end
        if (reg_req.rd) begin
            if (is_port_addr(reg_req.addr)) begin
                rdata_next = port_cfg_reg[reg_req.addr[3:0]];
            end else if (reg_req.addr == LPC_ADDR_INSTAT_LO) begin
                rdata_next = filt_reg[7:0] & input_mask[7:0];
            end else if (reg_req.addr == LPC_ADDR_INSTAT_HI) begin
                rdata_next = {6'h00, filt_reg[9:8] & input_mask[9:8]};
            end else if (reg_req.addr == LPC_ADDR_CONFIG) begin
                rdata_next = config_reg;
            end else if (reg_req.addr == LPC_ADDR_SCALE_LO) begin
                rdata_next = scale_lo_reg;
            end else if (reg_req.addr == LPC_ADDR_SCALE_HI) begin
                rdata_next = scale_hi_reg;
            end else if (reg_req.addr == LPC_ADDR_GLOBAL) begin
                rdata_next = global_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < N; i++) begin
                port_cfg_reg[i] <= LPC_RST_PORT;
            end
            // Pin variant comes up on the external clock
            config_reg   <= HAS_EXT_CLK ? LPC_RST_CONFIG_EXT : LPC_RST_CONFIG;
            scale_lo_reg <= LPC_RST_SCALE;
            scale_hi_reg <= LPC_RST_SCALE;
            global_reg   <= LPC_RST_GLOBAL;
            rdata_reg    <= 8'h00;
        end else begin
            port_cfg_reg <= port_cfg_next;
            config_reg   <= config_next;
            scale_lo_reg <= scale_lo_next;
            scale_hi_reg <= scale_hi_next;
            global_reg   <= global_next;
            rdata_reg    <= rdata_next;
        end
    end

    // Timebase: a level counts only once the second and third stages agree
    always_comb begin
        for (int b = 0; b < 11; b++) begin
            filt_next[b] = (sync2_reg[b] == sync3_reg[b]) ? sync3_reg[b] : filt_reg[b];
        end
        osc_tick     = (osc_cnt_reg == 13'(OSC_DIV - 1));
        osc_cnt_next = osc_tick ? 13'h0000 : osc_cnt_reg + 13'h0001;
        ext_tick     = filt_next[10] & ~filt_reg[10];
        pwm_tick     = config_reg[LPC_CFG_CLKSEL_BIT] ? ext_tick : osc_tick;
        pwm_cnt_next = pwm_tick ? pwm_cnt_reg + 8'h01 : pwm_cnt_reg;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg   <= 11'h000;
            sync2_reg   <= 11'h000;
            sync3_reg   <= 11'h000;
            filt_reg    <= 11'h000;
            osc_cnt_reg <= 13'h0000;
            pwm_cnt_reg <= 8'h00;
        end else begin
            sync1_reg   <= {ext_pwm_clock_in, port_io_in};
            sync2_reg   <= sync1_reg;
            sync3_reg   <= sync2_reg;
            filt_reg    <= filt_next;
            osc_cnt_reg <= osc_cnt_next;
            pwm_cnt_reg <= pwm_cnt_next;
        end
    end

    // Per-port drive; the open-drain level is always low, only its enable moves
    always_comb begin
        logic [7:0] code;
        logic [7:0] rel;
        logic       run;
        code       = 8'h00;
        rel        = 8'h00;
        run        = config_reg[LPC_CFG_RUN_BIT];
        drive_next = '0;
        drive_next.full = {scale_hi_reg[1:0], scale_lo_reg};
        for (int i = 0; i < N; i++) begin
            code = port_cfg_reg[i];
            rel  = pwm_cnt_reg - phase_of(i, config_reg[LPC_CFG_STAG_BIT]);
            drive_next.oe[i] = (code == LPC_CODE_LOW);
            if (run && code == LPC_CODE_STATIC) begin
                drive_next.sink[i] = 1'b1;
            end else if (run && is_pwm_code(code)) begin
                drive_next.sink[i] = (rel < code);
            end
            // Code 0xFF, 0x01 and shutdown leave the sink off
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            drive_reg <= '0;
        end else begin
            drive_reg <= drive_next;
        end
    end

    assign port_drive     = drive_reg;
    assign reg_rdata      = rdata_reg;
    assign global_current = global_reg[2:0];

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence s_period_end;
        pwm_tick && pwm_cnt_reg == LPC_PWM_LAST;
    endsequence

    sequence s_global_write;
        reg_req.wr && reg_req.addr == LPC_ADDR_GLOBAL;
    endsequence

    chk_hiz_code_off: assert property (
        port_cfg_reg[3] == 8'hFF |=> !port_drive.sink[3] && !port_drive.oe[3])
        else $error("off code drives port");
    chk_low_drive: assert property (
        port_cfg_reg[0] == LPC_CODE_LOW |=> port_drive.oe[0] && !port_drive.sink[0])
        else $error("logic low code not driven");
    chk_static_sink: assert property (
        config_reg[0] && port_cfg_reg[1] == LPC_CODE_STATIC |=> port_drive.sink[1])
        else $error("static sink not on");
    chk_shutdown_off: assert property (
        !config_reg[0] |=> port_drive.sink == 10'h000)
        else $error("sink on in shutdown");
    chk_period_wrap: assert property (
        s_period_end |=> pwm_cnt_reg == 8'h00 ##0 $past(pwm_cnt_reg, 1) == 8'hFF)
        else $error("period not 256 counts");
    chk_pwm_ontime: assert property (
        config_reg[0] && !config_reg[5] && port_cfg_reg[0] >= 8'h03 &&
        port_cfg_reg[0] <= 8'hFE |=> port_drive.sink[0] == ($past(pwm_cnt_reg) < $past(port_cfg_reg[0])))
        else $error("pwm on time wrong");
    chk_stagger_phase: assert property (
        config_reg[0] && config_reg[5] && port_cfg_reg[9] >= 8'h03 && port_cfg_reg[9] <= 8'hFE
        |=> port_drive.sink[9] == (8'($past(pwm_cnt_reg) - 8'h20) < $past(port_cfg_reg[9])))
        else $error("stagger phase wrong");
    chk_instat_mask: assert property (
        reg_req.rd && reg_req.addr == LPC_ADDR_INSTAT_LO && port_cfg_reg[1] != LPC_CODE_INPUT
        |=> !reg_rdata[1])
        else $error("non input status bit set");
    chk_status_ro: assert property (
        reg_req.wr && reg_req.addr == LPC_ADDR_INSTAT_HI
        |=> $stable(config_reg) && $stable(scale_lo_reg) && $stable(global_reg))
        else $error("status write changed state");
    chk_scale_map: assert property (
        ##1 port_drive.full == $past({scale_hi_reg[1:0], scale_lo_reg}))
        else $error("scale bits misplaced");
    chk_clksel_fixed: assert property (
        !HAS_EXT_CLK |-> !config_reg[7])
        else $error("clock select set without pin");
    chk_clksel_reset: assert property (
        $rose(arst_n) |-> config_reg[LPC_CFG_CLKSEL_BIT] == HAS_EXT_CLK)
        else $error("clock source wrong after reset");
    chk_global_out: assert property (
        s_global_write |=> global_current == $past(reg_req.wdata[2:0]))
        else $error("global current code not forwarded");
    chk_scale_high: assert property (
        reg_req.wr && reg_req.addr == LPC_ADDR_SCALE_HI
        |=> ##1 port_drive.full[9:8] == $past(reg_req.wdata[1:0], 2))
        else $error("high port scale bits misplaced");
    chk_ext_hold: assert property (
        config_reg[LPC_CFG_CLKSEL_BIT] && !ext_tick |=> $stable(pwm_cnt_reg))
        else $error("pwm count moved without external edge");
    chk_equal_ports: assert property (
        config_reg[LPC_CFG_RUN_BIT] && !config_reg[LPC_CFG_STAG_BIT] &&
        port_cfg_reg[0] == port_cfg_reg[9] |=> port_drive.sink[0] == port_drive.sink[9])
        else $error("equal ports out of step");
    chk_stagger_step: assert property (
        config_reg[LPC_CFG_RUN_BIT] && config_reg[LPC_CFG_STAG_BIT] &&
        is_pwm_code(port_cfg_reg[1])
        |=> port_drive.sink[1] ==
            (8'($past(pwm_cnt_reg) - LPC_STAGGER_STEP) < $past(port_cfg_reg[1])))
        else $error("port one phase wrong");
    chk_input_read: assert property (
        reg_req.rd && reg_req.addr == LPC_ADDR_INSTAT_LO && port_cfg_reg[3] == LPC_CODE_INPUT
        |=> reg_rdata[3] == $past(filt_reg[3]))
        else $error("input level not returned");
    chk_status_high: assert property (
        reg_req.rd && reg_req.addr == LPC_ADDR_INSTAT_HI |=> reg_rdata[7:2] == 6'h00)
        else $error("upper status bits set");
    chk_port_write: assert property (
        reg_req.wr && reg_req.addr == LPC_ADDR_PORT9
        |=> port_cfg_reg[9] == $past(reg_req.wdata) && $stable(port_cfg_reg[8]))
        else $error("port write not independent");

    // Per-port forms of the off, input, no-sink and static code checks, so every port is covered
    for (genvar p = 0; p < N; p++) begin : g_port_chk
        chk_port_off: assert property (
            port_cfg_reg[p] == 8'hFF |=> !port_drive.sink[p] && !port_drive.oe[p])
            else $error("off code drives port");
        chk_port_input: assert property (
            port_cfg_reg[p] == LPC_CODE_INPUT |=> !port_drive.sink[p] && !port_drive.oe[p])
            else $error("input code drives port");
        chk_port_nosink: assert property (
            !is_pwm_code(port_cfg_reg[p]) && port_cfg_reg[p] != LPC_CODE_STATIC
            |=> !port_drive.sink[p])
            else $error("non sink code sinks current");
        chk_port_static: assert property (
            config_reg[LPC_CFG_RUN_BIT] && port_cfg_reg[p] == LPC_CODE_STATIC
            |=> port_drive.sink[p])
            else $error("static sink not on");
    end
endmodule // lpc_port_pwm
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the ten-port PWM block
`default_nettype none
module tb_top import lpc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DIV = 4;
    localparam int PER = 256 * DIV;
    logic         clock = 1'b0;
    logic         arst_n = 1'b0;
    logic         ext_clk = 1'b0;
    lpc_reg_req_t req = '0;
    logic [7:0]   rdata;
    logic [7:0]   rdata_i;
    logic [9:0]   pins;
    logic [9:0]   ext_level = 10'h3FF;
    lpc_drive_t   drv;
    logic [2:0]   gcur;
    int           failures = 0;
    int           num_checks = 0;
    always #2.5 clock = ~clock;
    lpc_port_pwm #(.HAS_EXT_CLK(1'b1), .OSC_DIV(DIV)) dut (.clock(clock), .arst_n(arst_n),
        .reg_req(req), .reg_rdata(rdata), .ext_pwm_clock_in(ext_clk), .port_io_in(pins),
        .port_drive(drv), .global_current(gcur));
    // Internal-clock variant on the same bus; its read data is checked alongside
    lpc_port_pwm #(.HAS_EXT_CLK(1'b0), .OSC_DIV(DIV)) dut_int (.clock(clock), .arst_n(arst_n),
        .reg_req(req), .reg_rdata(rdata_i), .ext_pwm_clock_in(ext_clk), .port_io_in(pins),
        .port_drive(), .global_current());
    lpc_led_load load (.port_drive(drv), .ext_level(ext_level), .port_io_in(pins));
    task automatic note(input string what, input int ok);
        num_checks++;
        if (ok == 0) begin
            failures++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        note($sformatf("register %h expected %h", got, exp), int'(got === exp));
    endtask
    task automatic chk_pins(input logic [9:0] got, input logic [9:0] exp);
        note($sformatf("pins %h expected %h", got, exp), int'(got === exp));
    endtask
    task automatic chk_cnt(input int got, input int exp);
        note($sformatf("count %0d expected %0d", got, exp), int'(got == exp));
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        #1 req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        #1 req.rd = 1'b0;
        d = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Sink cycles of one port over exactly one internal PWM period
    task automatic pwm_hi(input int idx, output int hi);
        hi = 0;
        repeat (PER) begin
            settle(1);
            if (drv.sink[idx] === 1'b1) hi++;
        end
    endtask
    initial begin
        #200000;
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        logic [7:0] v;
        logic [9:0] prev;
        int hi;
        int rise [10];
        settle(16);
        arst_n = 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(i[7:0], v);
            chk_reg(v, 8'hFF);
        end
        rd(LPC_ADDR_CONFIG, v);
        chk_reg(v, 8'h80);
        chk_reg(rdata_i, 8'h00);
        rd(LPC_ADDR_GLOBAL, v);
        chk_reg(v, 8'h07);
        chk_pins(drv.sink | drv.oe, 10'h000);
        chk_pins(drv.out, 10'h000);
        $display("Test reset values done");
        for (int g = 0; g < 8; g++) begin
            wr(LPC_ADDR_GLOBAL, 8'hF8 | g[7:0]);
            settle(2);
            chk_reg({5'h00, gcur}, g[7:0]);
        end
        wr(LPC_ADDR_SCALE_LO, 8'hA5);
        wr(LPC_ADDR_SCALE_HI, 8'h02);
        settle(2);
        chk_pins(drv.full, 10'h2A5);
        $display("Test current scaling done");
        wr(8'h00, LPC_CODE_LOW);
        wr(8'h01, LPC_CODE_STATIC);
        wr(8'h02, 8'hFF);
        settle(3);
        chk_pins(drv.oe & 10'h007, 10'h001);
        chk_pins(drv.sink & 10'h007, 10'h000);
        rd(8'h01, v);
        chk_reg(v, LPC_CODE_STATIC);
        wr(LPC_ADDR_CONFIG, 8'h01);
        settle(3);
        chk_pins(drv.sink & 10'h007, 10'h002);
        chk_pins(drv.oe & 10'h007, 10'h001);
        $display("Test static codes done");
        wr(8'h03, LPC_CODE_INPUT);
        wr(8'h08, LPC_CODE_INPUT);
        ext_level = 10'h2F8;
        settle(8);
        rd(LPC_ADDR_INSTAT_LO, v);
        chk_reg(v, 8'h08);
        rd(LPC_ADDR_INSTAT_HI, v);
        chk_reg(v, 8'h00);
        ext_level = 10'h107;
        settle(8);
        rd(LPC_ADDR_INSTAT_LO, v);
        chk_reg(v, 8'h00);
        rd(LPC_ADDR_INSTAT_HI, v);
        chk_reg(v, 8'h01);
        wr(LPC_ADDR_INSTAT_LO, 8'hFF);
        wr(LPC_ADDR_INSTAT_HI, 8'hFF);
        rd(8'h03, v);
        chk_reg(v, LPC_CODE_INPUT);
        rd(LPC_ADDR_INSTAT_HI, v);
        chk_reg(v, 8'h01);
        $display("Test input readback done");
        foreach (rise[k]) begin
            v = (k == 0) ? 8'h03 : ((k == 1) ? 8'h80 : 8'hFE);
            if (k < 3) begin
                wr(8'h04, v);
                settle(3);
                pwm_hi(4, hi);
                chk_cnt(hi, int'(v) * DIV);
            end
        end
        $display("Test duty cycles done");
        for (int i = 0; i < 10; i++) wr(i[7:0], 8'h40);
        settle(3);
        hi = 0;
        repeat (PER) begin
            settle(1);
            if (drv.sink !== 10'h000 && drv.sink !== 10'h3FF) hi++;
        end
        chk_cnt(hi, 0);
        wr(LPC_ADDR_CONFIG, 8'h20);
        wr(LPC_ADDR_CONFIG, 8'h21);
        settle(3);
        foreach (rise[k]) rise[k] = -1;
        prev = drv.sink;
        for (int c = 0; c < PER + 64; c++) begin
            settle(1);
            foreach (rise[k]) if (drv.sink[k] && !prev[k] && rise[k] < 0) rise[k] = c;
            prev = drv.sink;
        end
        for (int k = 1; k < 10; k++) chk_cnt((rise[k] - rise[0] + PER) % PER, ((k * 32) % 256) * DIV);
        $display("Test phasing done");
        wr(LPC_ADDR_CONFIG, 8'h81);
        rd(LPC_ADDR_CONFIG, v);
        chk_reg(v, 8'h81);
        chk_reg(rdata_i, 8'h01);
        settle(8);
        hi = 0;
        prev = drv.sink;
        repeat (2 * PER) begin
            settle(1);
            if (drv.sink !== prev) hi++;
            prev = drv.sink;
        end
        chk_cnt(hi, 0);
        hi = 0;
        repeat (256) begin
            settle(4);
            ext_clk = 1'b1;
            settle(4);
            ext_clk = 1'b0;
            if (drv.sink[4] === 1'b1) hi++;
        end
        chk_cnt(hi, 8'h40);
        $display("Test external clock done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
